/* File: verilog/rca_defines.svh */
// constants shared by the execution datapath: file map, field positions, reset values
`ifndef RCA_DEFINES_SVH
`define RCA_DEFINES_SVH

// file addresses decoded inside the core
`define RCA_FILE_INDIRECT  7'h00
`define RCA_FILE_PCL       7'h02
`define RCA_FILE_STATUS    7'h03
`define RCA_FILE_FSR       7'h04

// status bit positions
`define RCA_ST_CARRY       0
`define RCA_ST_NIBBLE      1
`define RCA_ST_ZERO        2

// instruction word fields
`define RCA_IW_WIDTH       14
`define RCA_CLS_HI         13
`define RCA_CLS_LO         12
`define RCA_OP_HI          11
`define RCA_OP_LO          8
`define RCA_DEST_BIT       7
`define RCA_FADDR_HI       6
`define RCA_LIT_HI         7

// widths and reset values
`define RCA_DATA_WIDTH     8
`define RCA_FADDR_WIDTH    7
`define RCA_PC_WIDTH       11
`define RCA_W_RESET        8'h00
`define RCA_FSR_RESET      8'h00
`define RCA_IR_RESET       14'h0000

`endif

/* File: verilog/rca_pkg.sv */
// types of the execution datapath: instruction classes and alu operations
package rca_pkg;

    typedef enum logic [1:0] {
        rca_cls_file = 2'h0,
        rca_cls_none = 2'h1,
        rca_cls_goto = 2'h2,
        rca_cls_lit  = 2'h3
    } rca_class_type;

    typedef enum logic [3:0] {
        rca_op_mov  = 4'h0,
        rca_op_add  = 4'h1,
        rca_op_sub  = 4'h2,
        rca_op_and  = 4'h3,
        rca_op_or   = 4'h4,
        rca_op_xor  = 4'h5,
        rca_op_com  = 4'h6,
        rca_op_inc  = 4'h7,
        rca_op_dec  = 4'h8,
        rca_op_rlf  = 4'h9,
        rca_op_rrf  = 4'ha,
        rca_op_swap = 4'hb,
        rca_op_clr  = 4'hc,
        rca_op_movw = 4'hd
    } rca_op_type;

endpackage : rca_pkg

/* File: verilog/rca_alu.sv */
// 8-bit alu: arithmetic, boolean, shift and flag generation
`timescale 1ns/1ps
`default_nettype none
`include "rca_defines.svh"

module rca_alu
    import rca_pkg::*;
(
    // operation and operands
    input  wire logic [3:0] op,
    input  wire logic [7:0] w_operand,
    input  wire logic [7:0] f_operand,
    input  wire logic       carry_in,
    // result and flags
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            nibble_out,
    output logic            zero_out,
    output logic      [2:0] flag_update
);

    logic [8:0] sum9;
    logic [4:0] sum5;

    always_comb begin
        sum9        = {1'b0, f_operand} + {1'b0, w_operand};
        sum5        = {1'b0, f_operand[3:0]} + {1'b0, w_operand[3:0]};
        result      = f_operand;
        carry_out   = carry_in;
        nibble_out  = 1'b0;
        flag_update = 3'h0;
        case (op)
            rca_op_mov: begin
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_add: begin
                result      = sum9[7:0];
                carry_out   = sum9[8];
                nibble_out  = sum5[4];
                flag_update = 3'h7;
            end
            rca_op_sub: begin
                // add of the inverted w plus one: a set carry means no borrow
                sum9        = {1'b0, f_operand} + {1'b0, ~w_operand} + 9'h001;
                sum5        = {1'b0, f_operand[3:0]} + {1'b0, ~w_operand[3:0]} + 5'h01;
                result      = sum9[7:0];
                carry_out   = sum9[8];
                nibble_out  = sum5[4];
                flag_update = 3'h7;
            end
            rca_op_and: begin
                result = f_operand & w_operand;
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_or: begin
                result = f_operand | w_operand;
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_xor: begin
                result = f_operand ^ w_operand;
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_com: begin
                result = ~f_operand;
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_inc: begin
                result = f_operand + 8'h01;
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_dec: begin
                result = f_operand - 8'h01;
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_rlf: begin
                result    = {f_operand[6:0], carry_in};
                carry_out = f_operand[7];
                flag_update[`RCA_ST_CARRY] = 1'b1;
            end
            rca_op_rrf: begin
                result    = {carry_in, f_operand[7:1]};
                carry_out = f_operand[0];
                flag_update[`RCA_ST_CARRY] = 1'b1;
            end
            rca_op_swap: begin
                result = {f_operand[3:0], f_operand[7:4]};
            end
            rca_op_clr: begin
                result = 8'h00;
                flag_update[`RCA_ST_ZERO] = 1'b1;
            end
            rca_op_movw: begin
                result = w_operand;
            end
            default: begin
                result = f_operand;
            end
        endcase
        zero_out = (result == 8'h00);
    end

endmodule : rca_alu
`default_nettype wire

/* File: verilog/rca_core.sv */
// execution core: two-stage fetch/execute pipeline around the 8-bit alu
`timescale 1ns/1ps
`default_nettype none
`include "rca_defines.svh"

// Overview of operation
// - separate program and data buses, used concurrently
// - one 14-bit instruction word per fetch
// - fetch next word while current executes
// - single-cycle execution except program branches
// - pc addresses on-chip program memory only
// - pc, status, fsr file-mapped; direct and indirect
// - 8-bit add, subtract, shift, boolean operations
// - arithmetic is two's complement
// - two operands: w plus file or literal
// - single operand: w or one file
// - w register has no file address
// - flags carry, nibble, zero updated per instruction
// - subtraction carry and nibble flags mean no-borrow
module rca_core
    import rca_pkg::*;
#(
    parameter int PC_WIDTH = `RCA_PC_WIDTH
)(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // program memory bus
    output logic      [PC_WIDTH-1:0]    prog_addr,
    input  wire logic [13:0]            prog_data,
    // data memory bus
    output logic      [6:0]             data_addr,
    input  wire logic [7:0]             data_rdata,
    output logic      [7:0]             data_wdata,
    output logic                        data_we,
    // observation of core state
    output logic      [7:0]             w_value,
    output logic      [7:0]             status_value,
    output logic                        exec_pulse
);

    typedef struct packed {
        logic [PC_WIDTH-1:0] pc;
        logic [13:0]         ir;
        logic                ir_valid;
        logic [7:0]          w;
        logic [7:0]          fsr;
        logic                carry;
        logic                nibble_borrow_bit;
        logic                zero;
        logic                exec;
    } rca_state_type;

    rca_state_type state_reg;
    rca_state_type state_next;

    // decoded fields of the instruction in execute
    rca_class_type  iclass;
    logic [3:0]     iop;
    logic           idest;
    logic [6:0]     ifile;
    logic [7:0]     ilit;
    logic [6:0]     eff_addr;
    logic           internal_hit;
    logic [7:0]     file_value;

    // alu connections
    logic [7:0]     alu_f;
    logic [7:0]     alu_result;
    logic           alu_carry;
    logic           alu_nibble;
    logic           alu_zero;
    logic [2:0]     alu_update;

    logic           writes_file;
    logic           writes_w;

    // file addresses that the core answers itself rather than the data memory
    function automatic logic is_internal(input logic [6:0] addr);
        is_internal = (addr == `RCA_FILE_PCL) || (addr == `RCA_FILE_STATUS) ||
                      (addr == `RCA_FILE_FSR) || (addr == `RCA_FILE_INDIRECT);
    endfunction : is_internal

    function automatic logic [7:0] pack_status(input rca_state_type st);
        pack_status = 8'h00;
        pack_status[`RCA_ST_CARRY]  = st.carry;
        pack_status[`RCA_ST_NIBBLE] = st.nibble_borrow_bit;
        pack_status[`RCA_ST_ZERO]   = st.zero;
    endfunction : pack_status

    assign iclass = rca_class_type'(state_reg.ir[`RCA_CLS_HI:`RCA_CLS_LO]);
    assign iop    = state_reg.ir[`RCA_OP_HI:`RCA_OP_LO];
    assign idest  = state_reg.ir[`RCA_DEST_BIT];
    assign ifile  = state_reg.ir[`RCA_FADDR_HI:0];
    assign ilit   = state_reg.ir[`RCA_LIT_HI:0];

    // indirect access goes through fsr; fsr pointing at the indirect slot reads zero
    assign eff_addr     = (ifile == `RCA_FILE_INDIRECT) ?
                          state_reg.fsr[6:0] : ifile;
    assign internal_hit = is_internal(eff_addr);

    always_comb begin
        file_value = data_rdata;
        if (eff_addr == `RCA_FILE_PCL) begin
            file_value = state_reg.pc[7:0];
        end else if (eff_addr == `RCA_FILE_STATUS) begin
            file_value = pack_status(state_reg);
        end else if (eff_addr == `RCA_FILE_FSR) begin
            file_value = state_reg.fsr;
        end else if (eff_addr == `RCA_FILE_INDIRECT) begin
            file_value = 8'h00;
        end
    end

    // literal class: two-operand ops take the literal, single-operand ops act on w
    always_comb begin
        alu_f = file_value;
        if (iclass == rca_cls_lit) begin
            unique case (rca_op_type'(iop))
                rca_op_mov, rca_op_add, rca_op_sub,
                rca_op_and, rca_op_or, rca_op_xor: alu_f = ilit;
                default:                           alu_f = state_reg.w;
            endcase
        end
    end

    rca_alu u_alu (
        .op          (iop),
        .w_operand   (state_reg.w),
        .f_operand   (alu_f),
        .carry_in    (state_reg.carry),
        .result      (alu_result),
        .carry_out   (alu_carry),
        .nibble_out  (alu_nibble),
        .zero_out    (alu_zero),
        .flag_update (alu_update)
    );

    // file ops store to file when dest is set, else to w; store-w always goes to file
    assign writes_file = state_reg.ir_valid && (iclass == rca_cls_file) &&
                         (idest || (rca_op_type'(iop) == rca_op_movw));
    assign writes_w    = state_reg.ir_valid && !writes_file &&
                         ((iclass == rca_cls_file) || (iclass == rca_cls_lit));

    // data memory is accessed in the same cycle as the fetch on its own bus
    assign prog_addr  = state_reg.pc;
    assign data_addr  = eff_addr;
    assign data_wdata = alu_result;
    assign data_we    = writes_file && !internal_hit;

    assign w_value      = state_reg.w;
    assign status_value = pack_status(state_reg);
    assign exec_pulse   = state_reg.exec;

    always_comb begin
        state_next = state_reg;
        state_next.exec = state_reg.ir_valid;
        // prefetch the following word while the current one executes
        state_next.pc       = state_reg.pc + 1'b1;
        state_next.ir       = prog_data;
        state_next.ir_valid = 1'b1;
        if (state_reg.ir_valid) begin
            if (writes_w) begin
                state_next.w = alu_result;
            end
            if (writes_file && (eff_addr == `RCA_FILE_FSR)) begin
                state_next.fsr = alu_result;
            end
            if (writes_file && (eff_addr == `RCA_FILE_STATUS)) begin
                state_next.carry             = alu_result[`RCA_ST_CARRY];
                state_next.nibble_borrow_bit = alu_result[`RCA_ST_NIBBLE];
                state_next.zero              = alu_result[`RCA_ST_ZERO];
            end
            // alu flag updates win over a plain store to status, as in a real core
            if ((iclass == rca_cls_file) || (iclass == rca_cls_lit)) begin
                if (alu_update[`RCA_ST_CARRY]) begin
                    state_next.carry = alu_carry;
                end
                if (alu_update[`RCA_ST_NIBBLE]) begin
                    state_next.nibble_borrow_bit = alu_nibble;
                end
                if (alu_update[`RCA_ST_ZERO]) begin
                    state_next.zero = alu_zero;
                end
            end
            if (iclass == rca_cls_goto) begin
                // the prefetched word is stale: drop it, costing one extra cycle
                state_next.pc       = state_reg.ir[PC_WIDTH-1:0];
                state_next.ir_valid = 1'b0;
            end else if (writes_file && (eff_addr == `RCA_FILE_PCL)) begin
                state_next.pc[7:0]  = alu_result;
                state_next.ir_valid = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg.pc                <= '0;
            state_reg.ir                <= `RCA_IR_RESET;
            state_reg.ir_valid          <= 1'b0;
            state_reg.w                 <= `RCA_W_RESET;
            state_reg.fsr               <= `RCA_FSR_RESET;
            state_reg.carry             <= 1'b0;
            state_reg.nibble_borrow_bit <= 1'b0;
            state_reg.zero              <= 1'b0;
            state_reg.exec              <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : rca_core
`default_nettype wire

/* File: verification/rca_core_props.sv */
// concurrent checks on the execution core ports
`timescale 1ns/1ps
`default_nettype none
module rca_core_props #(
    parameter int PC_WIDTH = 11
)(
    // clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // program and data buses
    input wire logic [PC_WIDTH-1:0] prog_addr,
    input wire logic [13:0]         prog_data,
    input wire logic [6:0]          data_addr,
    input wire logic [7:0]          data_rdata,
    input wire logic [7:0]          data_wdata,
    input wire logic                data_we,
    // core state
    input wire logic [7:0]          w_value,
    input wire logic [7:0]          status_value,
    input wire logic                exec_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_reset_clear: assert property ($rose(rst_b) |-> prog_addr == '0 && !data_we && !exec_pulse)
        else $error("core not idle after reset");
    a_we_reserved: assert property (data_we |-> !(data_addr inside {7'h00, 7'h02, 7'h03, 7'h04}))
        else $error("store reached an internally decoded file");
    a_we_exec: assert property (data_we |=> exec_pulse)
        else $error("store without a completed instruction");
    a_w_kept_store: assert property (data_we |=> w_value == $past(w_value))
        else $error("working register moved on a file store");
    a_fetch_moves: assert property ($past(rst_b, 2) |-> prog_addr != $past(prog_addr))
        else $error("fetch address stood still");
    a_no_long_stall: assert property (!exec_pulse && $past(rst_b, 4) |=> exec_pulse)
        else $error("more than one bubble cycle");
    a_status_upper: assert property (status_value[7:3] == 5'h00)
        else $error("unused status bits set");
    a_w_on_exec: assert property ($changed(w_value) |-> exec_pulse)
        else $error("working register changed without execution");
    a_flags_on_exec: assert property ($changed(status_value) |-> exec_pulse)
        else $error("flags changed without execution");
endmodule : rca_core_props
`default_nettype wire

/* File: verification/rca_mem_model.sv */
// program rom and data file model beside the core
`timescale 1ns/1ps
`default_nettype none
module rca_mem_model #(
    parameter int PC_WIDTH = 11
)(
    // clock
    input wire logic                clk,
    // program bus
    input wire logic [PC_WIDTH-1:0] prog_addr,
    output logic     [13:0]         prog_data,
    // data bus
    input wire logic [6:0]          data_addr,
    output logic     [7:0]          data_rdata,
    input wire logic [7:0]          data_wdata,
    input wire logic                data_we,
    // bench loading and inspection
    input wire logic                ld_en,
    input wire logic [PC_WIDTH-1:0] ld_addr,
    input wire logic [13:0]         ld_word,
    input wire logic [6:0]          peek_addr,
    output logic     [7:0]          peek_data
);
    logic [13:0] rom [0:(1<<PC_WIDTH)-1];
    logic [7:0]  ram [0:127];
    logic        tick = 1'b0;

    always @(posedge clk) begin
        tick <= ~tick;
        if (ld_en) rom[ld_addr] <= ld_word;
        if (data_we) ram[data_addr] <= data_wdata;
    end
    // separate buses answer in the same cycle
    always_comb prog_data = rom[prog_addr];
    // decoded files never come from here, so feed a moving pattern to expose misuse
    always_comb data_rdata = (data_addr inside {7'h00, 7'h02, 7'h03, 7'h04}) ?
                             ({8{tick}} ^ {1'b0, data_addr}) : ram[data_addr];
    always_comb peek_data = ram[peek_addr];
endmodule : rca_mem_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int PCW = 9;  // small variant keeps rom loading short
    logic           clk = 1'b0;
    logic           rst_b = 1'b0;
    logic [PCW-1:0] prog_addr, ld_addr;
    logic [13:0]    prog_data, ld_word;
    logic [6:0]     data_addr, peek_addr;
    logic [7:0]     data_rdata, data_wdata, w_value, status_value, peek_data;
    logic           data_we, exec_pulse, ld_en;
    int             num_errors = 0;
    int             check_count = 0;
    int             cycles = 0;

    always #2.5 clk = ~clk;

    rca_core #(.PC_WIDTH(PCW)) i_rca_core (.clk(clk), .rst_b(rst_b), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr), .data_rdata(data_rdata),
        .data_wdata(data_wdata), .data_we(data_we), .w_value(w_value),
        .status_value(status_value), .exec_pulse(exec_pulse));
    rca_mem_model #(.PC_WIDTH(PCW)) i_rca_mem_model (.clk(clk), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr), .data_rdata(data_rdata),
        .data_wdata(data_wdata), .data_we(data_we), .ld_en(ld_en), .ld_addr(ld_addr),
        .ld_word(ld_word), .peek_addr(peek_addr), .peek_data(peek_data));

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check8

    // reset is asserted mid-run on purpose, rom is rewritten under it
    task automatic load(input logic [13:0] words[$]);
        @(posedge clk); #1;
        rst_b = 1'b0;
        for (int a = 0; a < (1 << PCW); a++) begin
            @(posedge clk); #1;
            ld_en = 1'b1;
            ld_addr = a[PCW-1:0];
            ld_word = (a < words.size()) ? words[a] : 14'h1000;
        end
        @(posedge clk); #1;
        ld_en = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
    endtask : load

    task automatic settle_peek(input logic [6:0] addr);
        repeat (20) @(posedge clk);
        #1 peek_addr = addr;
        #1;
    endtask : settle_peek

    task automatic count_exec(output logic [7:0] n);
        n = 8'h00;
        repeat (20) begin
            @(posedge clk); #1;
            if (exec_pulse === 1'b1) n++;
        end
    endtask : count_exec

    task automatic sc_arith;
        load('{14'h303c, 14'h31c4, 14'h0003, 14'h0da0, 14'h3010, 14'h3201, 14'h2006});
        settle_peek(7'h20);
        check8(peek_data, 8'h07, "carry nibble zero from add");
        check8(w_value, 8'hf1, "literal minus w");
        check8(status_value, 8'h02, "borrow flags");
    endtask : sc_arith

    task automatic sc_logic;
        load('{14'h30f0, 14'h333c, 14'h0da2, 14'h340f, 14'h0da3, 14'h353f, 14'h2006});
        settle_peek(7'h22);
        check8(peek_data, 8'h30, "and result");
        #1 peek_addr = 7'h23;
        #1 check8(peek_data, 8'h3f, "or result");
        check8(w_value, 8'h00, "xor result");
        check8(status_value, 8'h04, "zero only");
    endtask : sc_logic

    task automatic sc_file;
        load('{14'h3021, 14'h0d84, 14'h3081, 14'h0d80, 14'h09a1, 14'h0721, 14'h2006});
        settle_peek(7'h21);
        check8(peek_data, 8'h02, "indirect store then rotate");
        check8(w_value, 8'h03, "increment into w");
        check8(status_value, 8'h01, "rotate carry kept");
    endtask : sc_file

    task automatic sc_branch;
        logic [7:0] n;
        load('{14'h2002, 14'h30ff, 14'h3055, 14'h2003});
        repeat (10) @(posedge clk);
        count_exec(n);
        check8(w_value, 8'h55, "prefetched word discarded");
        check8(n, 8'h0a, "branch loop rate");
    endtask : sc_branch

    task automatic sc_stream;
        logic [7:0] n;
        load('{});
        repeat (10) @(posedge clk);
        count_exec(n);
        check8(n, 8'h14, "one instruction per cycle");
    endtask : sc_stream

    // counter read, single-operand ops on w, then a counter store that must flush
    task automatic sc_misc;
        load('{14'h0002, 14'h0da5, 14'h30a5, 14'h3600, 14'h3b00, 14'h3a00, 14'h0da6,
               14'h300b, 14'h0d82, 14'h30ee, 14'h30ee, 14'h3c00, 14'h200c});
        settle_peek(7'h25);
        check8(peek_data, 8'h01, "program counter read");
        #1 peek_addr = 7'h26;
        #1 check8(peek_data, 8'h52, "complement swap rotate on w");
        check8(w_value, 8'h00, "clear after counter store");
        check8(status_value, 8'h05, "rotate carry and clear zero");
    endtask : sc_misc

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // whole run needs about 3300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            $display("mismatch at %0t: run timed out", $time);
            wrap_up;
        end
    end

    initial begin
        ld_en = 1'b0;
        ld_addr = '0;
        ld_word = 14'h1000;
        peek_addr = 7'h00;
        sc_arith;
        sc_logic;
        sc_file;
        sc_branch;
        sc_stream;
        sc_misc;
        wrap_up;
    end
endmodule : tb_top

bind rca_core rca_core_props #(.PC_WIDTH(PC_WIDTH)) i_rca_core_props (.clk(clk), .rst_b(rst_b),
    .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
    .w_value(w_value), .status_value(status_value), .exec_pulse(exec_pulse));
`default_nettype wire
